// ### sse_pkg.sv
// Operation
// - each step stores frequency 1.0 to 550.0 Hz in 0.1 Hz units
// - frequency policy: programmed, keep previous, or linear ramp to target
// - waveform is sine, square, or user shape 1 to 16
// - waveform policy: programmed or keep previous, no ramp
// - start phase 0.0 to 359.9 degrees in 0.1 degree units
// - phase policy: programmed or keep previous, no ramp
// - two-bit step code drives two marker output lines
// - both marker lines low while idle
// - code policy: programmed or keep previous code
// - end-phase align flag per step; the stored end phase is not used, alignment is to zero
// - step end action: continue, go idle, or pause
// - jump target zero means next step, else that step
// - jump count zero is unlimited, else that many jumps
// - two trigger branch targets, zero disables the branch
// - values written to the current step reach the live output at once, except while idle
// - aligned step waits after its time until phase reaches zero
// - jump counter per step; count N runs loop N+1 times
// - step time 0.0001 to 999.9999 s, steps 1 to 255
// - keep policy ignores the stored value
package sse_pkg;
  // ************************************************************
  // bus map
  // ************************************************************
  localparam logic [11:0] SSE_CTRL_ADDR = 12'h000;
  localparam logic [11:0] SSE_STATUS_ADDR = 12'h004;
  localparam logic [11:0] SSE_SEL_ADDR = 12'h008;
  localparam logic [11:0] SSE_W0_ADDR = 12'h00C;
  localparam logic [11:0] SSE_W1_ADDR = 12'h010;
  localparam logic [11:0] SSE_W2_ADDR = 12'h014;
  localparam logic [11:0] SSE_W3_ADDR = 12'h018;
  localparam logic [11:0] SSE_OUTPUT_FREQUENCY_ADDR = 12'h01C;
  localparam logic [11:0] SSE_PHASE_ADDR = 12'h020;
  localparam logic [11:0] SSE_TICK_US = 12'h064;
  localparam logic [15:0] SSE_OUTPUT_FREQUENCY_MIN = 16'h000A;
  localparam logic [15:0] SSE_OUTPUT_FREQUENCY_MAX = 16'h157C;
  localparam logic [11:0] SSE_PHASE_WRAP = 12'hE10;
  localparam logic [9:0] SSE_JUMP_MAX = 10'h3E7;
  localparam logic [23:0] SSE_TIME_MAX = 24'h98967F;
  localparam int SSE_CLK_MHZ = 25;
  localparam int SSE_TICK_CYC = SSE_CLK_MHZ * 100;
  localparam logic [1:0] POL_SET = 2'h0;
  localparam logic [1:0] POL_KEEP = 2'h1;
  localparam logic [1:0] POL_RAMP = 2'h2;
  localparam logic [1:0] END_CONTINUE_SEQUENCE = 2'h0;
  localparam logic [1:0] END_IDLE = 2'h1;
  localparam logic [1:0] END_HOLD = 2'h2;
  localparam logic [4:0] SINE_SHAPE = 5'h00;
  localparam logic [4:0] SQUARE_SHAPE = 5'h01;
  localparam logic [4:0] USER_SHAPE_FIRST = 5'h02;
  localparam logic [4:0] USER_SHAPE_LAST = 5'h11;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_ALIGN = 4'b0100,
    ST_HOLD = 4'b1000
  } sse_state_t;

  typedef struct packed {
    logic [15:0] output_frequency;
    logic [1:0] output_frequency_pol;
    logic [4:0] shape;
    logic shape_keep;
    logic [11:0] phase;
    logic phase_keep;
    logic [1:0] code;
    logic code_keep;
    logic align_en;
    logic [11:0] end_phase;
    logic [1:0] end_act;
    logic [7:0] jump_to;
    logic [9:0] jump_num;
    logic [7:0] target_a;
    logic [7:0] target_b;
    logic [23:0] time_units;
  } sse_step_t;

  typedef struct packed {
    logic [15:0] output_frequency;
    logic [4:0] shape;
    logic [11:0] phase;
    logic [1:0] code;
  } sse_wave_t;

  function automatic logic [15:0] sse_clamp_output_frequency(input logic [15:0] f);
    if (f < SSE_OUTPUT_FREQUENCY_MIN) begin
      return SSE_OUTPUT_FREQUENCY_MIN;
    end else if (f > SSE_OUTPUT_FREQUENCY_MAX) begin
      return SSE_OUTPUT_FREQUENCY_MAX;
    end
    return f;
  endfunction

  function automatic logic [11:0] sse_clamp_phase(input logic [11:0] p);
    return (p >= SSE_PHASE_WRAP) ? 12'h000 : p;
  endfunction
endpackage

// ### sse_engine.sv
`timescale 1ns/100ps
`default_nettype none
module sse_engine import sse_pkg::*; #(
  parameter int STEPS = 256,
  parameter int TICK_CYC = SSE_TICK_CYC
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [11:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // triggers
  input wire logic trig_a_in,
  input wire logic trig_b_in,
  // waveform and markers
  output logic [15:0] output_frequency_out,
  output logic [4:0] shape_out,
  output logic [11:0] start_phase_out,
  output logic phase_load_out,
  output logic marker_bit_low_out,
  output logic marker_bit_high_out,
  output logic [3:0] state_out
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    sse_state_t st;
    logic [7:0] cur;
    logic [7:0] sel;
    logic [23:0] units;
    logic [15:0] tick;
    logic [15:0] from_f;
    logic [11:0] ph;
    sse_wave_t live;
    logic load;
    logic [1:0] ta_s;
    logic [1:0] tb_s;
    logic ta_d;
    logic tb_d;
    logic ap_wr;
    logic [11:0] ap_addr;
    logic [31:0] rdata;
  } sse_regs_t;

  sse_regs_t r, next_r;
  sse_step_t mem [STEPS];
  logic [9:0] jcnt [STEPS];
  sse_step_t s, w;
  logic mem_we, jc_we;
  logic [9:0] jc_val;
  logic [7:0] jc_idx;

  function automatic logic [7:0] sse_next(input logic [7:0] c);
    return (c == 8'hFF) ? 8'h01 : c + 8'h01;
  endfunction

  assign s = mem[r.cur];

  always_comb begin
    logic data_ph, do_end, go, stop, pause;
    logic [7:0] tgt;
    logic [39:0] prod;
    logic [16:0] diff;
    sse_step_t e;
    next_r = r;
    e = mem[r.cur];
    w = mem[r.sel];
    mem_we = 1'b0;
    jc_we = 1'b0;
    jc_val = 10'h000;
    jc_idx = r.cur;
    data_ph = r.ap_wr;
    do_end = 1'b0;
    go = 1'b0;
    stop = 1'b0;
    pause = 1'b0;
    tgt = 8'h00;
    prod = 40'h0;
    diff = 17'h0;
    next_r.load = 1'b0;
    // two flops per trigger line, then an edge detector
    next_r.ta_s = {r.ta_s[0], trig_a_in};
    next_r.tb_s = {r.tb_s[0], trig_b_in};
    next_r.ta_d = r.ta_s[1];
    next_r.tb_d = r.tb_s[1];
    next_r.ap_wr = 1'b0;
    // ************************************************************
    // bus slave, zero wait states
    // ************************************************************
    if (data_ph) begin
      mem_we = 1'b1;
      unique case (r.ap_addr)
        SSE_SEL_ADDR: begin
          next_r.sel = hwdata_in[7:0];
          mem_we = 1'b0;
        end
        SSE_W0_ADDR: begin
          w.output_frequency = sse_clamp_output_frequency(hwdata_in[15:0]);
          w.output_frequency_pol = hwdata_in[17:16];
          w.shape = (hwdata_in[22:18] > USER_SHAPE_LAST) ? SINE_SHAPE
                    : hwdata_in[22:18];
          w.shape_keep = hwdata_in[23];
          w.code = hwdata_in[25:24];
          w.code_keep = hwdata_in[26];
          w.phase_keep = hwdata_in[27];
          w.align_en = hwdata_in[28];
          w.end_act = (hwdata_in[30:29] == 2'h3) ? END_CONTINUE_SEQUENCE
                      : hwdata_in[30:29];
        end
        SSE_W1_ADDR: begin
          w.phase = sse_clamp_phase(hwdata_in[11:0]);
          w.end_phase = sse_clamp_phase(hwdata_in[23:12]);
          w.jump_to = hwdata_in[31:24];
        end
        SSE_W2_ADDR: begin
          w.jump_num = (hwdata_in[9:0] > SSE_JUMP_MAX) ? SSE_JUMP_MAX
                       : hwdata_in[9:0];
          w.target_a = hwdata_in[23:16];
          w.target_b = hwdata_in[31:24];
          jc_we = 1'b1;
          jc_idx = r.sel;
          jc_val = w.jump_num;
        end
        SSE_W3_ADDR: begin
          w.time_units = (hwdata_in[23:0] > SSE_TIME_MAX) ? SSE_TIME_MAX
                         : ((hwdata_in[23:0] == 24'h0) ? 24'h000001
                         : hwdata_in[23:0]);
        end
        SSE_CTRL_ADDR: begin
          mem_we = 1'b0;
          unique case (hwdata_in[1:0])
            2'h1: begin
              go = 1'b1;
              tgt = (hwdata_in[15:8] == 8'h00) ? 8'h01 : hwdata_in[15:8];
            end
            2'h2: begin
              stop = 1'b1;
            end
            2'h3: begin
              pause = (r.st != ST_IDLE);
            end
            default: if (r.st == ST_HOLD) next_r.st = ST_RUN;
          endcase
        end
        default: mem_we = 1'b0;
      endcase
      // live step edits act at once
      if (mem_we && r.sel == r.cur && r.st != ST_IDLE) begin
        next_r.load = 1'b1;
      end
    end
    if (hsel_in && hready_in && htrans_in[1]) begin
      next_r.ap_wr = hwrite_in;
      next_r.ap_addr = haddr_in;
      unique case (haddr_in)
        SSE_STATUS_ADDR: next_r.rdata = {20'h0, r.st, r.cur};
        SSE_SEL_ADDR: next_r.rdata = {24'h0, r.sel};
        SSE_OUTPUT_FREQUENCY_ADDR: next_r.rdata = {16'h0, r.live.output_frequency};
        SSE_PHASE_ADDR: next_r.rdata = {20'h0, r.ph};
        default: next_r.rdata = 32'h0;
      endcase
    end
    // ************************************************************
    // running phase accumulator, units of 0.1 degree
    // ************************************************************
    if (r.st != ST_IDLE && r.tick == 16'h0) begin
      // plus one so that the slowest tone still reaches a wrap
      diff = {1'b0, r.ph} + {5'h0, r.live.output_frequency[15:4]} + 17'h1;
      next_r.ph = (diff[11:0] >= SSE_PHASE_WRAP) ?
                  diff[11:0] - SSE_PHASE_WRAP : diff[11:0];
    end
    // ************************************************************
    // sequencer
    // ************************************************************
    // free-running tick: a step start jitters by under one tick
    next_r.tick = (r.tick == 16'(TICK_CYC - 1)) ? 16'h0 : r.tick + 16'h1;
    unique case (r.st)
      ST_IDLE: next_r.live.code = 2'h0;
      ST_RUN: begin
        if (r.tick == 16'h0) begin
          next_r.units = r.units + 24'h1;
          if (s.output_frequency_pol == POL_RAMP) begin
            // forty bits: top frequency times the longest step time
            prod = 40'(r.from_f) * 40'(s.time_units - r.units);
            prod = prod + 40'(s.output_frequency) * 40'(r.units);
            next_r.live.output_frequency = 16'(prod / 40'(s.time_units));
          end
          if (r.units + 24'h1 >= s.time_units) begin
            if (s.output_frequency_pol == POL_RAMP) next_r.live.output_frequency = s.output_frequency;
            if (s.align_en) next_r.st = ST_ALIGN;
            else do_end = 1'b1;
          end
        end
      end
      ST_ALIGN: if (r.tick == 16'h0 && diff[11:0] >= SSE_PHASE_WRAP) begin
        do_end = 1'b1;
        next_r.ph = 12'h000;
      end
      default: ;
    endcase
    if (do_end) begin
      if (s.jump_to != 8'h00 &&
          (s.jump_num == 10'h0 || jcnt[r.cur] != 10'h0)) begin
        tgt = s.jump_to;
        jc_we = (s.jump_num != 10'h0);
        jc_val = jcnt[r.cur] - 10'h1;
      end else begin
        tgt = sse_next(r.cur);
        jc_we = 1'b1;
        jc_val = s.jump_num;
      end
      jc_idx = r.cur;
      unique case (s.end_act)
        END_IDLE: next_r.st = ST_IDLE;
        END_HOLD: next_r.st = ST_HOLD;
        default: go = 1'b1;
      endcase
      if (!go) tgt = 8'h00;
    end
    if (r.st != ST_IDLE) begin
      if (r.ta_s[1] && !r.ta_d && s.target_a != 8'h00) begin
        go = 1'b1;
        tgt = s.target_a;
      end else if (r.tb_s[1] && !r.tb_d && s.target_b != 8'h00) begin
        go = 1'b1;
        tgt = s.target_b;
      end
    end
    if (go && tgt != 8'h00) begin
      next_r.cur = tgt;
      next_r.st = ST_RUN;
      next_r.units = 24'h0;
      next_r.from_f = r.live.output_frequency;
      next_r.load = 1'b1;
    end
    // software stop and pause win over a step end or a trigger
    if (stop) begin
      next_r.st = ST_IDLE;
    end else if (pause) begin
      next_r.st = ST_HOLD;
    end
    // an edit of the live step is not in memory yet: use the new word
    if (mem_we && r.sel == next_r.cur) begin
      e = w;
    end else begin
      e = mem[next_r.cur];
    end
    // apply policies of the step being entered
    if (next_r.load) begin
      next_r.live.output_frequency = (e.output_frequency_pol == POL_SET) ?
        e.output_frequency : next_r.live.output_frequency;
      if (!e.shape_keep) begin
        next_r.live.shape = e.shape;
      end
      if (!e.phase_keep) begin
        next_r.live.phase = e.phase;
        next_r.ph = e.phase;
      end
      if (!e.code_keep) begin
        next_r.live.code = e.code;
      end
    end
    if (next_r.st == ST_IDLE) next_r.live.code = 2'h0;
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      r <= '{st: ST_IDLE, live: '{output_frequency: SSE_OUTPUT_FREQUENCY_MIN, default: '0},
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  // no reset on step memory: software programs every step it enters
  always_ff @(posedge mclk_in) begin
    if (mem_we) mem[r.sel] <= w;
    if (jc_we) jcnt[jc_idx] <= jc_val;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign hrdata_out = r.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign output_frequency_out = r.live.output_frequency;
  assign shape_out = r.live.shape;
  assign start_phase_out = r.live.phase;
  assign phase_load_out = r.load;
  assign marker_bit_low_out = r.live.code[0];
  assign marker_bit_high_out = r.live.code[1];
  assign state_out = r.st;
endmodule
`default_nettype wire

// ### sse_engine_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// port checks for the step engine
// ************************************************************
module sse_engine_checker import sse_pkg::*; (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // bus side
  input wire logic hsel_in,
  input wire logic [11:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  // outputs watched
  input wire logic [15:0] output_frequency_out,
  input wire logic [4:0] shape_out,
  input wire logic [11:0] start_phase_out,
  input wire logic phase_load_out,
  input wire logic marker_bit_low_out,
  input wire logic marker_bit_high_out,
  input wire logic [3:0] state_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic ctrl_wr;
  assign ctrl_wr = hsel_in && hready_in && htrans_in[1] && hwrite_in
    && haddr_in == SSE_CTRL_ADDR;
  property p_output_frequency_range;
    output_frequency_out >= SSE_OUTPUT_FREQUENCY_MIN
      && output_frequency_out <= SSE_OUTPUT_FREQUENCY_MAX;
  endproperty
  a_output_frequency_range: assert property (p_output_frequency_range)
    else $error("frequency out of range");
  property p_shape_range;
    shape_out <= USER_SHAPE_LAST;
  endproperty
  a_shape_range: assert property (p_shape_range)
    else $error("shape code out of range");
  property p_phase_range;
    start_phase_out < SSE_PHASE_WRAP;
  endproperty
  a_phase_range: assert property (p_phase_range)
    else $error("start phase out of range");
  property p_idle_low;
    (state_out == ST_IDLE) [*2] |-> !marker_bit_low_out
      && !marker_bit_high_out;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("marker lines high while idle");
  property p_state_onehot;
    $onehot(state_out);
  endproperty
  a_state_onehot: assert property (p_state_onehot)
    else $error("state not one-hot");
  property p_hold_still;
    (state_out == ST_HOLD) [*3] ##0 !phase_load_out
      |-> $stable(output_frequency_out)
      && $stable({marker_bit_high_out, marker_bit_low_out});
  endproperty
  a_hold_still: assert property (p_hold_still)
    else $error("outputs moved while paused");
  property p_leave_idle;
    $past(state_out) == ST_IDLE && state_out != ST_IDLE
      |-> $past(ctrl_wr, 1) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3);
  endproperty
  a_leave_idle: assert property (p_leave_idle)
    else $error("left idle without a control write");
  property p_stop_ctrl;
    ctrl_wr && state_out == ST_RUN ##1 hwdata_in[1:0] == 2'h2
      |-> ##[1:3] state_out == ST_IDLE;
  endproperty
  a_stop_ctrl: assert property (p_stop_ctrl)
    else $error("stop did not reach idle");
endmodule
`default_nettype wire

// ### sse_trig_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// far side: trigger source
// ************************************************************
module sse_trig_model (
  // clock
  input wire logic mclk_in,
  // requests from bench
  input wire logic fire_a_in,
  input wire logic fire_b_in,
  // trigger lines
  output logic trig_a_out,
  output logic trig_b_out
);
  logic [2:0] cnt_a = 3'h0;
  logic [2:0] cnt_b = 3'h0;
  // level held six cycles so one event is one edge only
  always @(posedge mclk_in) begin
    cnt_a <= fire_a_in ? 3'h6 : (cnt_a != 3'h0 ? cnt_a - 3'h1 : 3'h0);
    cnt_b <= fire_b_in ? 3'h6 : (cnt_b != 3'h0 ? cnt_b - 3'h1 : 3'h0);
  end
  assign trig_a_out = cnt_a != 3'h0;
  assign trig_b_out = cnt_b != 3'h0;
endmodule
`default_nettype wire

// ### sse_testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// bench top
// ************************************************************
module testbench import sse_pkg::*;;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic fire_a = 1'b0;
  logic fire_b = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd, hrdata;
  logic hready, hresp, trig_a, trig_b, pl, mlo, mhi;
  logic [15:0] output_frequency;
  logic [4:0] shape;
  logic [11:0] phase;
  logic [3:0] state;
  int n_fail = 0;
  int n_checks = 0;
  int n_load = 0;
  sse_engine #(.STEPS(256), .TICK_CYC(4)) dut (.mclk_in(mclk_in),
    .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .trig_a_in(trig_a),
    .trig_b_in(trig_b), .output_frequency_out(output_frequency),
    .shape_out(shape), .start_phase_out(phase), .phase_load_out(pl),
    .marker_bit_low_out(mlo), .marker_bit_high_out(mhi),
    .state_out(state));
  sse_trig_model partner (.mclk_in(mclk_in), .fire_a_in(fire_a),
    .fire_b_in(fire_b), .trig_a_out(trig_a), .trig_b_out(trig_b));
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (pl === 1'b1) n_load++;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task rdy;
    int i;
    i = 0;
    @(posedge mclk_in);
    while (hready !== 1'b1) begin
      i++;
      if (i > 20) begin
        n_fail++;
        give_verdict;
      end
      @(posedge mclk_in);
    end
  endtask
  task bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task wait_st(input logic [3:0] s);
    for (int i = 0; i < 400; i++) begin
      @(posedge mclk_in);
      if (state === s) return;
    end
    n_fail++;
    give_verdict;
  endtask
  function automatic logic [31:0] w0(input logic [15:0] f,
      input logic [1:0] fp, input logic [4:0] sh, input logic shk,
      input logic [1:0] cd, input logic cdk, input logic [1:0] ea);
    return {1'b0, ea, 2'b00, cdk, cd, shk, sh, fp, f};
  endfunction
  task prog(input logic [7:0] s, input logic [31:0] a, b, c, d);
    bus(SSE_SEL_ADDR, 1'b1, {24'h0, s});
    bus(SSE_W0_ADDR, 1'b1, a);
    bus(SSE_W1_ADDR, 1'b1, b);
    bus(SSE_W2_ADDR, 1'b1, c);
    bus(SSE_W3_ADDR, 1'b1, d);
  endtask
  task start(input logic [7:0] s);
    n_load = 0;
    bus(SSE_CTRL_ADDR, 1'b1, {16'h0, s, 8'h01});
    wait_st(ST_RUN);
  endtask
  task t_reset;
    chk("output_frequency", {16'h0, output_frequency}, 32'd10);
    chk("markers", {30'h0, mhi, mlo}, 32'h0);
    chk("phase", {20'h0, phase}, 32'h0);
    bus(SSE_STATUS_ADDR, 1'b0, 32'h0);
    chk("status", {28'h0, rd[11:8]}, 32'h1);
    bus(12'h100, 1'b0, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("done reset");
  endtask
  task t_policy;
    prog(8'h1, w0(16'd500, POL_SET, SQUARE_SHAPE, 0, 2'h2, 0, END_CONTINUE_SEQUENCE),
      32'h0, 32'h0, 32'd3);
    prog(8'h2, w0(16'd1000, POL_RAMP, SINE_SHAPE, 1, 2'h1, 1, END_IDLE),
      32'h0, 32'h0, 32'd8);
    start(8'h1);
    tick(2);
    chk("code", {30'h0, mhi, mlo}, 32'h2);
    chk("shape", {27'h0, shape}, {27'h0, SQUARE_SHAPE});
    chk("output_frequency", {16'h0, output_frequency}, 32'd500);
    for (int i = 0; i < 40 && n_load < 2; i++) tick(1);
    tick(16);
    chk("keep code", {30'h0, mhi, mlo}, 32'h2);
    chk("keep shape", {27'h0, shape}, {27'h0, SQUARE_SHAPE});
    chk("ramp", {31'h0, output_frequency > 16'd500 && output_frequency < 16'd1000}, 32'h1);
    wait_st(ST_IDLE);
    chk("ramp end", {16'h0, output_frequency}, 32'd1000);
    chk("idle code", {30'h0, mhi, mlo}, 32'h0);
    $display("done policy");
  endtask
  task t_trig;
    prog(8'h3, w0(16'd500, POL_SET, SINE_SHAPE, 0, 2'h1, 0, END_CONTINUE_SEQUENCE),
      32'h0, 32'h0005_0000, 32'd9999);
    prog(8'h5, w0(16'd700, POL_SET, SQUARE_SHAPE, 0, 2'h3, 0, END_HOLD),
      32'h0, 32'h0, 32'd2);
    start(8'h3);
    fire_b <= 1'b1;
    tick(1);
    fire_b <= 1'b0;
    tick(10);
    bus(SSE_STATUS_ADDR, 1'b0, 32'h0);
    chk("no branch", {24'h0, rd[7:0]}, 32'h3);
    bus(SSE_CTRL_ADDR, 1'b1, 32'h2);
    wait_st(ST_IDLE);
    start(8'h3);
    fire_a <= 1'b1;
    tick(1);
    fire_a <= 1'b0;
    wait_st(ST_HOLD);
    tick(4);
    bus(SSE_STATUS_ADDR, 1'b0, 32'h0);
    chk("branch", {24'h0, rd[7:0]}, 32'h5);
    chk("code", {30'h0, mhi, mlo}, 32'h3);
    bus(SSE_CTRL_ADDR, 1'b1, 32'h2);
    wait_st(ST_IDLE);
    $display("done trigger");
  endtask
  task t_jump;
    prog(8'h6, w0(16'd800, POL_SET, SINE_SHAPE, 0, 2'h0, 0, END_CONTINUE_SEQUENCE),
      32'h0600_0000, 32'd2, 32'd2);
    prog(8'h7, w0(16'd800, POL_KEEP, SINE_SHAPE, 0, 2'h1, 0, END_IDLE),
      32'h0, 32'h0, 32'd2);
    for (int r = 0; r < 2; r++) begin
      start(8'h6);
      wait_st(ST_IDLE);
      chk("entries", n_load, 32'd4);
    end
    $display("done jump");
  endtask
  task t_live;
    prog(8'h8, w0(16'd6000, POL_SET, USER_SHAPE_LAST, 0, 2'h1, 0, END_CONTINUE_SEQUENCE)
      | 32'h1000_0000, 32'h0000_0384, 32'h0, 32'd4);
    prog(8'h9, w0(16'd0, POL_KEEP, SINE_SHAPE, 1, 2'h0, 1, END_HOLD)
      | 32'h0800_0000, 32'h0, 32'h0, 32'h0);
    start(8'h8);
    tick(1);
    chk("start phase", {20'h0, phase}, 32'd900);
    chk("user shape", {27'h0, shape}, {27'h0, USER_SHAPE_LAST});
    chk("output_frequency max", {16'h0, output_frequency}, {16'h0, SSE_OUTPUT_FREQUENCY_MAX});
    wait_st(ST_ALIGN);
    wait_st(ST_HOLD);
    bus(SSE_STATUS_ADDR, 1'b0, 32'h0);
    chk("after align", {24'h0, rd[7:0]}, 32'h9);
    chk("keep phase", {20'h0, phase}, 32'd900);
    chk("keep output_frequency", {16'h0, output_frequency}, {16'h0, SSE_OUTPUT_FREQUENCY_MAX});
    bus(SSE_W0_ADDR, 1'b1,
      w0(16'd2000, POL_SET, SINE_SHAPE, 0, 2'h2, 0, END_HOLD));
    chk("resp", {31'h0, hresp}, 32'h0);
    tick(1);
    chk("live output_frequency", {16'h0, output_frequency}, 32'd2000);
    chk("live code", {30'h0, mhi, mlo}, 32'h2);
    bus(SSE_CTRL_ADDR, 1'b1, 32'h2);
    wait_st(ST_IDLE);
    $display("done live");
  endtask
  task t_loop;
    prog(8'hA, w0(16'd300, POL_SET, SINE_SHAPE, 0, 2'h3, 0, END_CONTINUE_SEQUENCE),
      32'h0A00_0000, 32'h0, 32'd1);
    start(8'hA);
    tick(60);
    chk("endless", {31'h0, n_load > 10}, 32'h1);
    bus(SSE_CTRL_ADDR, 1'b1, 32'h2);
    wait_st(ST_IDLE);
    chk("stop code", {30'h0, mhi, mlo}, 32'h0);
    $display("done loop");
  endtask
  initial begin
    tick(3);
    reset_in <= 1'b0;
    tick(1);
    t_reset;
    t_policy;
    t_trig;
    t_jump;
    t_live;
    t_loop;
    give_verdict;
  end
endmodule
bind sse_engine sse_engine_checker u_chk (.mclk_in, .reset_in, .hsel_in,
  .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in,
  .output_frequency_out, .shape_out, .start_phase_out, .phase_load_out,
  .marker_bit_low_out, .marker_bit_high_out, .state_out);
`default_nettype wire
